// file: core/pmcc_top.sv
// pm event latching and processor clock control
//
// Overview of operation
// - Ring pin sets ring status; enable gives resume, plus SCI if routed.
// - General input pin sets its status; enabled it raises SMI, SCI, resume.
// - USB activity in power-on suspend sets status; resume, SCI if routed.
// - Thermal override entry sets its status and throttles at thermal duty.
// - Thermal input at selected level sets thermal status; SCI or SMI.
// - Event status bits set by hardware only; write one clears them.
// - Enable register gates lid, ring, input, USB and thermal events.
// - Read-only clock control status reads one while clock control active.
// - Clock-run enabled: request PCI clock stop after 26 idle clocks.
// - Stop-clock enable: level three stops the host clock.
// - Burst enable: events reload burst timers, else break to full speed.
// - Level reads enter clock modes only with clock control enabled.
// - Throttle enable runs periodic stop-clock throttling.
// - Duty code 001 is 87.5%, each step 12.5% less; 000 reserved.
// - Level-two byte read returns zero, enters stop grant; writes ignored.
// - Level-three byte read returns zero, enters stop clock; writes ignored.
// - Interrupt resume from power-on suspend sets IRQ resume status.
// - External SMI request sets its status; write one clears.
// - Global standby expiry sets its status; write one clears.
// - General summary bit reads one while any general status is set.
// - Power management summary reads one while any pm status is set.
// - Thermal polarity one selects active low, zero active high.
`timescale 1ns/1ps
module pmcc_top
  import pmcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // i/o register window
  input  wire logic [7:2]  io_addr,
  input  wire logic [3:0]  io_be,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [31:0] io_wdata,
  output logic      [31:0] io_rdata,
  output logic             io_rvalid,
  // event pins
  input  wire logic        ring_indicate_in_n,
  input  wire logic        gen_input_pin_n,
  input  wire logic        thermal_alert_in,
  input  wire logic        lid_in,
  input  wire logic        ext_smi_request_in_n,
  // on-chip events and settings
  input  wire logic        usb_activity,
  input  wire logic        pos_active,
  input  wire logic        irq_resume,
  input  wire logic        standby_expired,
  input  wire logic        pm_status_any,
  input  wire logic        sci_route_enable,
  input  wire logic        thermal_polarity,
  input  wire logic        lid_polarity,
  input  wire logic [2:0]  thermal_duty_ratio,
  input  wire logic        pci_bus_idle,
  // requests and clock control
  output logic             sci_req,
  output logic             smi_req,
  output logic             resume_req,
  output logic             clkrun_stop_req,
  output logic             cpu_stop_clock_out_n,
  output logic             cpu_sleep_out_n,
  output logic             host_clk_stop,
  output logic             burst_reload,
  output logic             stop_break
);

  // --------------------------------------------------------------
  // state and helpers
  // --------------------------------------------------------------
  pmcc_st_type q, d;
  pmcc_thr_if  thr ();

  logic [15:0] set_gp;
  logic [15:0] set_gl;
  logic [15:0] clr_gp;
  logic [15:0] clr_gl;
  logic [15:0] trig;
  logic        thrm_act;
  logic        lid_act;
  logic        level_two_state_rd;
  logic        level_three_state_rd;
  logic        gp_any;

  // lane hit for a register at a byte offset
  function automatic logic hit(input logic [7:2] a,
                               input logic [3:0] be,
                               input logic [7:0] off);
    hit = (a == off[7:2]) && be[off[1:0]];
  endfunction : hit

  // 16-bit half of a dword write for a register at off
  function automatic logic [15:0] half(input logic [31:0] w,
                                       input logic [7:0]  off);
    half = off[1] ? w[31:16] : w[15:0];
  endfunction : half

  pmcc_throttle u_thr (
    .clk (clk),
    .rst (rst),
    .thr (thr.gen)
  );

  // --------------------------------------------------------------
  // event detection
  // --------------------------------------------------------------
  always_comb
  begin
    // sync order: ring, gpi, thermal, lid, ext smi
    thrm_act = thermal_polarity ? !q.sy2[2] : q.sy2[2];
    lid_act  = lid_polarity ? !q.sy2[3] : q.sy2[3];
    set_gp           = RST16;
    set_gp[B_RING]   = !q.sy2[0];
    set_gp[B_GPI]    = !q.sy2[1];
    set_gp[B_USB]    = usb_activity && pos_active;
    set_gp[B_THOR]   = thrm_act && !q.thr_ovr;
    set_gp[B_THRM]   = thrm_act;
    set_gp[B_LID]    = lid_act;
    set_gl           = RST16;
    set_gl[G_IRQ]    = irq_resume && pos_active;
    set_gl[G_EXT]    = !q.sy2[4];
    set_gl[G_STBY]   = standby_expired;
    clr_gp = (io_wr && hit(io_addr, io_be, OFF_GENERAL_EVENT_STATUS))
           ? half(io_wdata, OFF_GENERAL_EVENT_STATUS) : RST16;
    clr_gl = (io_wr && hit(io_addr, io_be, OFF_GLOBAL_EVENT_STATUS))
           ? half(io_wdata, OFF_GLOBAL_EVENT_STATUS) : RST16;
    level_two_state_rd = io_rd && hit(io_addr, io_be, OFF_LEVEL_TWO_STATE);
    level_three_state_rd = io_rd && hit(io_addr, io_be, OFF_LEVEL_THREE_STATE);
    gp_any  = |(q.gsts & GENERAL_EVENT_STATUS_MASK);
    // fresh enabled events break or reload clock control
    trig = set_gp & ~q.gsts & q.gen;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    d     = q;
    d.sy1 = {!ext_smi_request_in_n ? 1'b0 : 1'b1, lid_in,
             thermal_alert_in, gen_input_pin_n, ring_indicate_in_n};
    d.sy1[4] = ext_smi_request_in_n;
    d.sy2 = q.sy1;

    // set wins over a write-one clear
    d.gsts = ((q.gsts & ~clr_gp) | set_gp) & GENERAL_EVENT_STATUS_MASK;
    d.glb  = ((q.glb & ~clr_gl) | set_gl) & GLB_MASK;

    if (io_wr && hit(io_addr, io_be, OFF_GENERAL_EVENT_ENABLE))
      d.gen = half(io_wdata, OFF_GENERAL_EVENT_ENABLE) & GENERAL_EVENT_ENABLE_MASK;
    if (io_wr && hit(io_addr, io_be, OFF_PROCESSOR_CLOCK_CONTROL))
      d.pctl = io_wdata[15:0] & PCTL_MASK;
    // level registers take no write

    // override follows the thermal input
    d.thr_ovr = thrm_act;

    // requests: status AND enable, held while status stands
    d.rsm = |(q.gsts & q.gen & 16'h0F00);
    d.sci = sci_route_enable
          && |(q.gsts & q.gen & 16'h0F01);
    d.smi = !sci_route_enable
          && |(q.gsts & q.gen & 16'h0A01);

    // pci clock-run idle count
    if (!pci_bus_idle)
      d.idle = 5'h00;
    else if (q.idle != IDLE_CLKS)
      d.idle = q.idle + 5'h01;
    d.clkrun = q.pctl[P_CLKRUN] && d.idle == IDLE_CLKS;

    // clock mode entry and exit
    d.reload = 1'b0;
    d.brk    = 1'b0;
    if (q.mode == MODE_RUN && q.pctl[P_CCEN])
    begin
      if (level_three_state_rd)
        d.mode = MODE_LEVEL_THREE_STATE;
      else if (level_two_state_rd)
        d.mode = MODE_LEVEL_TWO_STATE;
    end
    if (|trig)
    begin
      if (q.pctl[P_BURST])
        d.reload = 1'b1;
      else if (q.mode != MODE_RUN)
      begin
        d.brk  = 1'b1;
        d.mode = MODE_RUN;
      end
    end

    // processor clock pins
    d.stpclk_n  = !(q.mode != MODE_RUN || thr.stop);
    d.slp_n     = !(q.mode == MODE_LEVEL_THREE_STATE
                    && q.pctl[P_SLEEP]);
    d.hclk_stop = q.mode == MODE_LEVEL_THREE_STATE
                  && q.pctl[P_STPCLK];

    // register reads
    d.rvalid = io_rd;
    d.rdata  = RST32;
    if (io_rd && io_addr == OFF_GENERAL_EVENT_STATUS[7:2])
      d.rdata = {q.gen, q.gsts};
    else if (io_rd && io_addr == OFF_PROCESSOR_CLOCK_CONTROL[7:2])
    begin
      d.rdata[15:0]    = q.pctl;
      d.rdata[P_CCSTS] = q.mode != MODE_RUN || thr.run;
    end
    else if (io_rd && io_addr == OFF_GLOBAL_EVENT_STATUS[7:2])
    begin
      d.rdata[15:0]  = q.glb;
      d.rdata[G_GP]  = gp_any;
      d.rdata[G_PM]  = pm_status_any;
    end
    // level registers read as zero
  end

  // throttle run: thermal override uses its own duty
  always_comb
  begin
    thr.run  = q.thr_ovr || q.pctl[P_THTEN];
    thr.duty = q.thr_ovr ? thermal_duty_ratio
                         : q.pctl[P_DUTY +: 3];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q          <= '0;
      q.sy1      <= SYNC_IDLE;
      q.sy2      <= SYNC_IDLE;
      q.stpclk_n <= 1'b1;
      q.slp_n    <= 1'b1;
    end
    else
      q <= d;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign io_rdata             = q.rdata;
  assign io_rvalid            = q.rvalid;
  assign sci_req              = q.sci;
  assign smi_req              = q.smi;
  assign resume_req           = q.rsm;
  assign clkrun_stop_req      = q.clkrun;
  assign cpu_stop_clock_out_n = q.stpclk_n;
  assign cpu_sleep_out_n      = q.slp_n;
  assign host_clk_stop        = q.hclk_stop;
  assign burst_reload         = q.reload;
  assign stop_break           = q.brk;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence level_three_state_entry_s;
    level_three_state_rd && q.mode == MODE_RUN && q.pctl[P_CCEN] && !(|trig);
  endsequence

  sequence level_three_state_held_s;
    q.mode == MODE_LEVEL_THREE_STATE ##1 !cpu_stop_clock_out_n;
  endsequence

  ring_set_a: assert property (
    !q.sy2[0] |=> q.gsts[B_RING])
    else $error("ring status not set");
  w1c_clear_a: assert property (
    clr_gp[B_GPI] && !set_gp[B_GPI] |=> !q.gsts[B_GPI])
    else $error("write one did not clear status");
  set_wins_a: assert property (
    set_gp[B_RING] && clr_gp[B_RING] |=> q.gsts[B_RING])
    else $error("clear beat a same-cycle set");
  resume_hold_a: assert property (
    q.gsts[B_RING] && q.gen[B_RING] |=> resume_req)
    else $error("enabled ring gave no resume");
  level_three_state_enter_a: assert property (
    level_three_state_entry_s |=> level_three_state_held_s)
    else $error("level three not entered");
  lvl_gated_a: assert property (
    (level_two_state_rd || level_three_state_rd) && !q.pctl[P_CCEN]
      && q.mode == MODE_RUN |=> q.mode == MODE_RUN)
    else $error("level read acted with control off");
  sleep_out_a: assert property (
    q.mode == MODE_LEVEL_THREE_STATE && q.pctl[P_SLEEP] |=> !cpu_sleep_out_n)
    else $error("sleep not asserted in level three");
  clkrun_idle_a: assert property (
    $rose(clkrun_stop_req) |-> q.idle == IDLE_CLKS
      && $past(pci_bus_idle, 1))
    else $error("clock stop asked before idle count");
  gp_summary_a: assert property (
    io_rd && io_addr == OFF_GLOBAL_EVENT_STATUS[7:2]
      |=> io_rvalid && io_rdata[G_GP] == $past(gp_any))
    else $error("summary bit wrong");
  break_a: assert property (
    |trig && !q.pctl[P_BURST] && q.mode != MODE_RUN
      |=> stop_break && q.mode == MODE_RUN)
    else $error("stop break missing");

endmodule : pmcc_top

// file: core/pmcc_pkg.sv
// constants and types of the pm event and cpu clock control block
package pmcc_pkg;

  // register offsets in the pm i/o window
  localparam logic [7:0] OFF_GENERAL_EVENT_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_GENERAL_EVENT_ENABLE   = 8'h0E;
  localparam logic [7:0] OFF_PROCESSOR_CLOCK_CONTROL = 8'h10;
  localparam logic [7:0] OFF_LEVEL_TWO_STATE   = 8'h14;
  localparam logic [7:0] OFF_LEVEL_THREE_STATE   = 8'h15;
  localparam logic [7:0] OFF_GLOBAL_EVENT_STATUS = 8'h18;

  // general event status / enable bit positions
  localparam int B_LID  = 11;
  localparam int B_RING = 10;
  localparam int B_GPI  = 9;
  localparam int B_USB  = 8;
  localparam int B_THOR = 7;
  localparam int B_THRM = 0;

  // processor clock control bit positions
  localparam int P_CCSTS  = 17;
  localparam int P_CLKRUN = 13;
  localparam int P_STPCLK = 12;
  localparam int P_SLEEP  = 11;
  localparam int P_BURST  = 10;
  localparam int P_CCEN   = 9;
  localparam int P_THTEN  = 4;
  localparam int P_DUTY   = 1;

  // global status bit positions
  localparam int G_IRQ  = 11;
  localparam int G_EXT  = 10;
  localparam int G_STBY = 8;
  localparam int G_GP   = 7;
  localparam int G_PM   = 6;

  // writable masks and reset values
  localparam logic [15:0] GENERAL_EVENT_STATUS_MASK = 16'h0F81;
  localparam logic [15:0] GENERAL_EVENT_ENABLE_MASK  = 16'h0F01;
  localparam logic [15:0] PCTL_MASK  = 16'h3E1E;
  localparam logic [15:0] GLB_MASK   = 16'h0D00;
  localparam logic [15:0] RST16      = 16'h0000;
  localparam logic [31:0] RST32      = 32'h0000_0000;

  // pci idle clocks before clock stop is requested
  localparam logic [4:0] IDLE_CLKS = 5'h1A;
  // pin sync idle levels: active-low pins high, level pins low
  localparam logic [4:0] SYNC_IDLE = 5'h13;
  // last count of a throttle step (16 clock cycles a step), eight steps a period
  localparam logic [3:0] THR_STEP_CYC = 4'hF;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_LEVEL_TWO_STATE,
    MODE_LEVEL_THREE_STATE
  } pmcc_mode_type;

  typedef struct packed {
    logic [4:0]    sy1;
    logic [4:0]    sy2;
    logic [15:0]   gsts;
    logic [15:0]   gen;
    logic [15:0]   pctl;
    logic [15:0]   glb;
    pmcc_mode_type mode;
    logic [4:0]    idle;
    logic          thr_ovr;
    logic          sci;
    logic          smi;
    logic          rsm;
    logic          clkrun;
    logic          stpclk_n;
    logic          slp_n;
    logic          hclk_stop;
    logic          reload;
    logic          brk;
    logic [31:0]   rdata;
    logic          rvalid;
  } pmcc_st_type;

  typedef struct packed {
    logic [3:0] cnt;
    logic [2:0] phase;
    logic       stop;
  } pmcc_thr_type;

endpackage : pmcc_pkg

// file: core/pmcc_thr_if.sv
// throttle request and stop-clock answer between control and generator
`timescale 1ns/1ps
interface pmcc_thr_if;
  logic       run;
  logic [2:0] duty;
  logic       stop;
  modport ctl (output run, output duty, input stop);
  modport gen (input run, input duty, output stop);
endinterface : pmcc_thr_if

// file: core/pmcc_throttle.sv
// stop-clock duty generator for throttling
`timescale 1ns/1ps
module pmcc_throttle
  import pmcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // throttle link
  pmcc_thr_if.gen  thr
);

  pmcc_thr_type q, d;

  always_comb
  begin
    d = q;
    if (!thr.run)
    begin
      d = '0;
    end
    else
    begin
      d.cnt = q.cnt + 4'h1;
      if (q.cnt == THR_STEP_CYC)
      begin
        d.cnt   = 4'h0;
        d.phase = q.phase + 3'h1;
      end
      // asserted for 8 - duty of 8 steps, code 000 gives none
      d.stop = (thr.duty != 3'h0)
             && ({1'b0, d.phase} < (4'h8 - {1'b0, thr.duty}));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign thr.stop = q.stop;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  duty_zero_a: assert property (
    thr.run && thr.duty == 3'h0 |=> !thr.stop)
    else $error("throttle asserted with reserved duty");
  idle_stop_a: assert property (
    !thr.run |=> !thr.stop)
    else $error("stop asserted while not throttling");

endmodule : pmcc_throttle

// file: testbench/pmcc_far_model.sv
// far-side model: processor clock pins and pci bus activity
`timescale 1ns/1ps
module pmcc_far_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench control
  input  wire logic       bus_quiet,
  input  wire logic       measure,
  // device outputs watched
  input  wire logic       stop_n,
  input  wire logic       brk,
  input  wire logic       rld,
  // to device and bench
  output logic            pci_bus_idle,
  output logic [8:0]      low_cnt,
  output logic [3:0]      brk_cnt,
  output logic [3:0]      rld_cnt
);
  // bus idle for as long as the bench keeps it quiet
  assign pci_bus_idle = bus_quiet;

  // low-time counter for duty checks, pulse tallies
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt <= '0;
      brk_cnt <= '0;
      rld_cnt <= '0;
    end
    else
    begin
      low_cnt <= measure ? low_cnt + 9'(!stop_n) : '0;
      brk_cnt <= brk_cnt + 4'(brk);
      rld_cnt <= rld_cnt + 4'(rld);
    end
  end
endmodule : pmcc_far_model

// file: testbench/testbench.sv
// self-checking bench for the pm event and clock control block
`timescale 1ns/1ps
module testbench
  import pmcc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0;
  logic [7:2] io_addr = '0;
  logic [3:0] io_be = '0;
  logic [31:0] io_wdata = '0, io_rdata;
  logic ring_n = 1'b1, gpi_n = 1'b1, ext_n = 1'b1, alert = 1'b0;
  logic lid = 1'b0, usb = 1'b0, irq = 1'b0, stby = 1'b0, pm_any = 1'b0;
  logic route = 1'b1, pol = 1'b0, quiet = 1'b0, measure = 1'b0;
  logic pos = 1'b1;
  logic [2:0] tduty = 3'h4;
  logic io_rvalid, sci, smi, rsm, ckr, stop_n, sleep_n, hstop, rld, brk;
  logic idle;
  logic [8:0] low_cnt;
  logic [3:0] brk_cnt, rld_cnt, c0;
  logic [15:0] m;
  int fail_count = 0, checks = 0, n;
  int ev[4] = '{B_RING, B_GPI, B_USB, B_LID};

  always #10 clk = ~clk;

  pmcc_top uut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_be(io_be),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .ring_indicate_in_n(ring_n), .gen_input_pin_n(gpi_n),
    .thermal_alert_in(alert), .lid_in(lid), .ext_smi_request_in_n(ext_n),
    .usb_activity(usb), .pos_active(pos), .irq_resume(irq),
    .standby_expired(stby), .pm_status_any(pm_any),
    .sci_route_enable(route), .thermal_polarity(pol),
    .lid_polarity(1'b0), .thermal_duty_ratio(tduty), .pci_bus_idle(idle),
    .sci_req(sci), .smi_req(smi), .resume_req(rsm), .clkrun_stop_req(ckr),
    .cpu_stop_clock_out_n(stop_n), .cpu_sleep_out_n(sleep_n),
    .host_clk_stop(hstop), .burst_reload(rld), .stop_break(brk));

  pmcc_far_model far (.clk(clk), .rst(rst), .bus_quiet(quiet),
    .measure(measure), .stop_n(stop_n), .brk(brk), .rld(rld),
    .pci_bus_idle(idle), .low_cnt(low_cnt), .brk_cnt(brk_cnt),
    .rld_cnt(rld_cnt));

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string msg);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_word({31'h0, got}, {31'h0, exp}, msg);
  endtask : chk_bit

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    wt(1);
    io_addr = a[7:2];
    io_be = b;
    io_wdata = d;
    io_wr = 1'b1;
    wt(1);
    io_wr = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] exp, input string msg);
    wt(1);
    io_addr = a[7:2];
    io_be = b;
    io_rd = 1'b1;
    wt(1);
    io_rd = 1'b0;
    chk_bit(io_rvalid, 1'b1, "read answer");
    chk_word(io_rdata, exp, msg);
  endtask : rdc

  task automatic fire(input int k);
    wt(1);
    case (k)
      B_RING: ring_n = 1'b0;
      B_GPI: gpi_n = 1'b0;
      B_USB: usb = 1'b1;
      default: lid = 1'b1;
    endcase
    wt(4);
    {ring_n, gpi_n, usb, lid} = 4'hC;
    wt(2);
  endtask : fire

  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    wt(8);
    rst = 1'b0;
    chk_bit(stop_n, 1'b1, "stop idle");
    chk_bit(sleep_n, 1'b1, "sleep idle");
    rdc(OFF_GENERAL_EVENT_STATUS, 4'hF, '0, "gp regs");
    rdc(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, '0, "control");
    rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, '0, "global");
    $display("test reset done");
    foreach (ev[i])
    begin
      m = 16'h1 << ev[i];
      fire(ev[i]);
      rdc(OFF_GENERAL_EVENT_STATUS, 4'h3, {16'h0, m}, "event status");
      rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h80, "gp summary");
      wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, {m, 16'h0});
      wt(2);
      chk_bit(rsm, 1'b1, "resume");
      chk_bit(sci, 1'b1, "sci");
      wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h0);
      rdc(OFF_GENERAL_EVENT_STATUS, 4'hF, {m, m}, "zero write");
      wr(OFF_GENERAL_EVENT_STATUS, 4'h3, {16'h0, m});
      wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, 32'h0);
      wt(2);
      chk_bit(rsm, 1'b0, "resume off");
      rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0, "gp summary off");
    end
    ring_n = 1'b0;
    wt(4);
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400);
    rdc(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400, "set wins");
    ring_n = 1'b1;
    {pos, usb, irq} = 3'b011;
    wt(3);
    {pos, usb, irq} = 3'b100;
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400);
    rdc(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h0, "outside suspend");
    rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0, "no irq resume");
    $display("test general events done");
    route = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      {pol, alert} = {p[0], p[0]};
      wt(4);
      alert = ~p[0];
      wt(4);
      alert = p[0];
      wt(4);
      rdc(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h81, "thermal");
      wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, 32'h0001_0000);
      wt(2);
      chk_bit(smi, 1'b1, "thermal smi");
      chk_bit(sci, 1'b0, "thermal sci");
      wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h81);
      wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, 32'h0);
    end
    {pol, alert, route} = 3'b001;
    // polarity swap ahead of the synced pin gives a brief thermal event
    wt(4);
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h81);
    $display("test thermal done");
    {ext_n, stby, irq, pm_any} = 4'h7;
    wt(1);
    {stby, irq} = 2'b00;
    wt(4);
    ext_n = 1'b1;
    rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0D40, "global");
    wr(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0);
    rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0D40, "global kept");
    pm_any = 1'b0;
    wr(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0D00);
    rdc(OFF_GLOBAL_EVENT_STATUS, 4'h3, 32'h0, "global clear");
    $display("test global status done");
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'hFFFF_FFFF);
    rdc(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h0002_3E1E, "control bits");
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h0);
    rdc(OFF_LEVEL_TWO_STATE, 4'h1, 32'h0, "level_two_state off");
    wr(OFF_LEVEL_TWO_STATE, 4'h3, 32'hFFFF);
    wt(3);
    chk_bit(stop_n, 1'b1, "no entry");
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h200);
    rdc(OFF_LEVEL_TWO_STATE, 4'h1, 32'h0, "level_two_state");
    wt(2);
    chk_bit(stop_n, 1'b0, "level_two_state stop");
    chk_bit(hstop, 1'b0, "level_two_state host");
    rdc(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h0002_0200, "cc active");
    wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, 32'h0400_0000);
    c0 = brk_cnt;
    fire(B_RING);
    chk_word({28'h0, brk_cnt}, {28'h0, 4'(c0 + 4'h1)}, "break");
    chk_bit(stop_n, 1'b1, "full speed");
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400);
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h1E00);
    rdc(OFF_LEVEL_THREE_STATE, 4'h2, 32'h0, "level_three_state");
    wt(2);
    chk_bit(hstop, 1'b1, "host stop");
    chk_bit(sleep_n, 1'b0, "sleep");
    c0 = rld_cnt;
    fire(B_RING);
    chk_word({28'h0, rld_cnt}, {28'h0, 4'(c0 + 4'h1)}, "reload");
    chk_bit(hstop, 1'b1, "burst keeps");
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400);
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h1A00);
    c0 = brk_cnt;
    fire(B_RING);
    chk_word({28'h0, brk_cnt}, {28'h0, 4'(c0 + 4'h1)}, "break 3");
    chk_bit(hstop, 1'b0, "host runs");
    chk_bit(sleep_n, 1'b1, "awake");
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h400);
    wr(OFF_GENERAL_EVENT_ENABLE, 4'hC, 32'h0);
    $display("test clock modes done");
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h2000);
    quiet = 1'b1;
    n = 0;
    while (ckr !== 1'b1 && n < 40)
    begin
      wt(1);
      n++;
    end
    chk_bit(n >= 26 && n <= 28, 1'b1, "clock stop delay");
    if (n >= 40)
      give_verdict();
    quiet = 1'b0;
    wt(2);
    chk_bit(ckr, 1'b0, "clock stop drop");
    for (int c = 0; c < 8; c++)
    begin
      wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'(16 + c * 2));
      wt(150);
      measure = 1'b1;
      wt(128);
      measure = 1'b0;
      n = (c == 0) ? 0 : (8 - c) * 16;
      chk_word({23'h0, low_cnt}, 32'(n), "duty");
    end
    wr(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h0);
    tduty = 3'h2;
    alert = 1'b1;
    wt(150);
    measure = 1'b1;
    wt(128);
    measure = 1'b0;
    chk_word({23'h0, low_cnt}, 32'h60, "thermal duty");
    rdc(OFF_PROCESSOR_CLOCK_CONTROL, 4'hF, 32'h0002_0000, "cc thermal");
    alert = 1'b0;
    wt(4);
    wr(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h81);
    rdc(OFF_GENERAL_EVENT_STATUS, 4'h3, 32'h0, "thermal clear");
    $display("test clock run and throttle done");
    give_verdict();
  end
endmodule : testbench
